// ===== core/qsu_ctrl.sv
// Controller end of the synchronous SRAM user port, with the memory array.
// Assumes the core clock is the positive leg of the system clock pair.
`timescale 1ns/1ps
`include "qsu_defs.svh"


module qsu_ctrl (
  input wire logic i_core_clk,          // System clock, positive leg
  input wire logic i_sys_clk_n,         // System clock, negative leg
  input wire logic i_reset,             // Async system reset, active high
  qsu_if.ctrl bus,                      // User port
  output qsu_pkg::qsu_dbg_t o_debug_bus // Debug, left open by the user
);
  import qsu_pkg::*;

  // Derived sizes, all from the shared constants header
  localparam int NP = `QSU_PORTS;
  localparam int LAT = `QSU_RD_LAT;
  localparam int LANES = (`QSU_MEMORY_DATA_WIDTH_PARAM / `QSU_LANE_BITS) * `QSU_BURST_BEATS;
  localparam int LB = `QSU_LANE_BITS;
  localparam logic [7:0] CAL_LAST = 8'(`QSU_CAL_CYCLES - 1);

  // Reset and calibration state
  logic rst_meta_q;                     // Reset synchroniser, first stage
  logic rst_sync_q;                     // Synchronised user reset
  qsu_cal_e cal_state_q;                // Calibration state
  logic [7:0] cal_cnt_q;                // Calibration cycle count
  logic cal_done_q;                     // Calibration finished
  logic clk_n_q;                        // Sampled negative leg

  // Per-port view of the requests after the calibration gate
  logic rd_req [NP];                    // Accepted read strobes
  qsu_addr_t rd_addr [NP];              // Read addresses
  logic wr_req [NP];                    // Accepted write strobes
  qsu_addr_t wr_addr [NP];              // Write addresses
  qsu_data_t wr_data [NP];              // Write bursts
  qsu_mask_t wr_mask [NP];              // Active-low masks

  // Storage and the read return pipelines
  qsu_data_t mem_q [0:`QSU_MEM_DEPTH-1];   // Memory words
  logic [LAT-1:0] vld_q [NP];           // Read-valid pipeline
  qsu_data_t dat_q [NP][LAT];           // Read-data pipeline

  // User clock is the core clock itself
  assign bus.user_clk = i_core_clk;
  assign bus.user_rst = rst_sync_q;
  assign bus.calib_done = cal_done_q;

  // Reset synchroniser: async assert, clocked release
  // The user reset leaves two edges after the system reset is released
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= 1'b1;
    end else begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Read calibration: count out the calibration time after reset
  // Done never falls again except through a reset
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      cal_state_q <= QSU_CAL_HOLD;
      cal_cnt_q <= 8'h00;
      cal_done_q <= 1'b0;
    end else if (rst_sync_q) begin
      // Held in reset
      cal_state_q <= QSU_CAL_HOLD;
      cal_cnt_q <= 8'h00;
      cal_done_q <= 1'b0;
    end else begin
      unique case (cal_state_q)
        QSU_CAL_HOLD: begin
          cal_state_q <= QSU_CAL_RUN;
        end
        QSU_CAL_RUN: begin
          // Finish after the last calibration cycle
          if (cal_cnt_q == CAL_LAST) begin
            cal_state_q <= QSU_CAL_DONE;
            cal_done_q <= 1'b1;
          end else begin
            cal_cnt_q <= cal_cnt_q + 8'h01;
          end
        end
        QSU_CAL_DONE: begin
          cal_done_q <= 1'b1;
        end
        default: begin
          // Unused code: start calibration again
          cal_state_q <= QSU_CAL_HOLD;
        end
      endcase
    end
  end

  // Port A requests, gated by calibration
  // A strobe before calibration neither touches memory nor returns data
  always_comb begin
    rd_req[0] = bus.port_a_read_request & cal_done_q;
    rd_addr[0] = bus.port_a_read_location;
    wr_req[0] = bus.port_a_write_request & cal_done_q;
    wr_addr[0] = bus.port_a_write_location;
    wr_data[0] = bus.port_a_write_burst_bus;
    wr_mask[0] = bus.port_a_byte_write_mask_low;
  end

  // Port B exists only in the two-word burst setup
  // It shares the gate and the pipeline shape of port A
  generate
    if (NP == 2) begin : g_port_b
      always_comb begin
        rd_req[NP-1] = bus.port_b_read_request & cal_done_q;
        rd_addr[NP-1] = bus.port_b_read_location;
        wr_req[NP-1] = bus.port_b_write_request & cal_done_q;
        wr_addr[NP-1] = bus.port_b_write_location;
        wr_data[NP-1] = bus.port_b_write_burst_bus;
        wr_mask[NP-1] = bus.port_b_byte_write_mask_low;
      end
      // Return path of port B
      assign bus.port_b_read_return_strobe = vld_q[NP-1][LAT-1];
      assign bus.port_b_read_burst_bus = dat_q[NP-1][LAT-1];
    end else begin : g_no_port_b
      // Undriven port B inputs are never looked at
      assign bus.port_b_read_return_strobe = 1'b0;
      assign bus.port_b_read_burst_bus = '0;
    end
  endgenerate

  // Port A return path, straight from the last pipeline stage
  // Port A exists in both burst setups
  assign bus.port_a_read_return_strobe = vld_q[0][LAT-1];
  assign bus.port_a_read_burst_bus = dat_q[0][LAT-1];

  // Memory access: reads sample old contents, then writes land
  // A read and a write of one word in one cycle: the read takes the old
  // word, since both updates are non-blocking
  always_ff @(posedge i_core_clk) begin
    for (int p = 0; p < NP; p++) begin
      if (rd_req[p]) begin
        dat_q[p][0] <= mem_q[rd_addr[p]];
      end
      for (int s = 1; s < LAT; s++) begin
        dat_q[p][s] <= dat_q[p][s-1];
      end
    end
    // Byte lanes with a low mask bit are written; port B wins a tie
    // A high mask bit keeps that lane as it was
    for (int p = 0; p < NP; p++) begin
      if (wr_req[p]) begin
        for (int b = 0; b < LANES; b++) begin
          if (!wr_mask[p][b]) begin
            mem_q[wr_addr[p]][b*LB +: LB] <= wr_data[p][b*LB +: LB];
          end
        end
      end
    end
  end

  // Read-valid pipeline, cleared while the user reset is high
  // A reset in mid-run drops reads in flight; their data is lost
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int p = 0; p < NP; p++) begin
        vld_q[p] <= '0;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (rst_sync_q) begin
          vld_q[p] <= '0;
        end else begin
          vld_q[p] <= {vld_q[p][LAT-2:0], rd_req[p]};
        end
      end
    end
  end

  // Debug bus: clock-pair health and calibration progress
  // Bit 7 only shows that the negative leg toggles; nothing else uses it
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      clk_n_q <= 1'b0;
      o_debug_bus <= 8'h00;
    end else begin
      clk_n_q <= i_sys_clk_n;
      o_debug_bus <= {clk_n_q, cal_done_q, cal_cnt_q[5:0]};
    end
  end
endmodule

// ===== core/qsu_defs.svh
// Constants for the synchronous SRAM user port: widths, burst setup, timing.
// Assumes it is included by bare name from the package, the controller end, the user-logic end and the testbench.
`ifndef QSU_DEFS_SVH
`define QSU_DEFS_SVH

// Memory data width per beat, in bits (nine bits per byte lane)
`define QSU_MEMORY_DATA_WIDTH_PARAM 18
// Bits per byte lane
`define QSU_LANE_BITS 9
// Burst beats: 2 selects the two-word burst setup, 4 the four-word one
`define QSU_BURST_BEATS 2
// Number of user ports; the second exists only with two-word bursts
`define QSU_PORTS ((`QSU_BURST_BEATS == 2) ? 2 : 1)
// User address width
`define QSU_ADDR_W 8
// Memory words held by the internal array
`define QSU_MEM_DEPTH 256
// Cycles from read strobe to read-return strobe
`define QSU_RD_LAT 3
// Read calibration time in ns and the core clock rate in MHz
`define QSU_CAL_TIME_NS 2000
`define QSU_CLK_MHZ 25
// Calibration cycles, rounded up
`define QSU_CAL_CYCLES ((`QSU_CAL_TIME_NS * `QSU_CLK_MHZ + 999) / 1000)
// Request FIFO depth on the user end
`define QSU_FIFO_DEPTH 32

`endif

// ===== core/qsu_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and an active-high asynchronous reset.
`timescale 1ns/1ps

module qsu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic i_core_clk,          // Core clock
  input wire logic i_reset,             // Async reset, active high
  input wire logic i_in_valid,          // Source offers a word
  output logic o_in_ready,              // Room for a word
  input wire logic [WIDTH-1:0] i_in_data, // Word in
  output logic o_out_valid,             // A word is held
  input wire logic i_out_ready,         // Sink takes the word
  output logic [WIDTH-1:0] o_out_data   // Oldest word
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [0:DEPTH-1];  // Storage
  logic [PW-1:0] wr_ptr_q;              // Next slot to fill
  logic [PW-1:0] rd_ptr_q;              // Oldest slot
  logic [PW:0] count_q;                 // Words held
  logic push;
  logic pop;

  // Full and empty straight from the count
  assign o_in_ready = (count_q != PW'(0) + (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign o_out_valid = (count_q != '0);
  assign o_out_data = mem_q[rd_ptr_q];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  // Storage write
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + PW'(1);
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + PW'(1);
      end
      // Simultaneous push and pop leaves the count alone
      if (push && !pop) begin
        count_q <= count_q + (PW+1)'(1);
      end else if (pop && !push) begin
        count_q <= count_q - (PW+1)'(1);
      end
    end
  end
endmodule

// ===== core/qsu_if.sv
// Carrier joining the controller end and the user-logic end.
// Assumes both ends run on the core clock; no clocking block.
`timescale 1ns/1ps

interface qsu_if;
  logic user_clk;                                // User clock from controller
  logic user_rst;                                // Synchronised user reset
  logic calib_done;                              // Calibration finished
  logic port_a_read_request;                     // Port A read strobe
  qsu_pkg::qsu_addr_t port_a_read_location;      // Port A read address
  logic port_a_read_return_strobe;               // Port A read data valid
  qsu_pkg::qsu_data_t port_a_read_burst_bus;     // Port A read data
  logic port_a_write_request;                    // Port A write strobe
  qsu_pkg::qsu_addr_t port_a_write_location;     // Port A write address
  qsu_pkg::qsu_data_t port_a_write_burst_bus;    // Port A write data
  qsu_pkg::qsu_mask_t port_a_byte_write_mask_low; // Port A byte mask
  logic port_b_read_request;                     // Port B read strobe
  qsu_pkg::qsu_addr_t port_b_read_location;      // Port B read address
  logic port_b_read_return_strobe;               // Port B read data valid
  qsu_pkg::qsu_data_t port_b_read_burst_bus;     // Port B read data
  logic port_b_write_request;                    // Port B write strobe
  qsu_pkg::qsu_addr_t port_b_write_location;     // Port B write address
  qsu_pkg::qsu_data_t port_b_write_burst_bus;    // Port B write data
  qsu_pkg::qsu_mask_t port_b_byte_write_mask_low; // Port B byte mask

  // Controller end
  modport ctrl (
    output user_clk, user_rst, calib_done,
    input port_a_read_request, port_a_read_location,
    output port_a_read_return_strobe, port_a_read_burst_bus,
    input port_a_write_request, port_a_write_location, port_a_write_burst_bus,
    input port_a_byte_write_mask_low,
    input port_b_read_request, port_b_read_location,
    output port_b_read_return_strobe, port_b_read_burst_bus,
    input port_b_write_request, port_b_write_location, port_b_write_burst_bus,
    input port_b_byte_write_mask_low
  );

  // User-logic end
  modport user (
    input user_clk, user_rst, calib_done,
    output port_a_read_request, port_a_read_location,
    input port_a_read_return_strobe, port_a_read_burst_bus,
    output port_a_write_request, port_a_write_location, port_a_write_burst_bus,
    output port_a_byte_write_mask_low,
    output port_b_read_request, port_b_read_location,
    input port_b_read_return_strobe, port_b_read_burst_bus,
    output port_b_write_request, port_b_write_location, port_b_write_burst_bus,
    output port_b_byte_write_mask_low
  );
endinterface

// ===== core/qsu_pkg.sv
// Types shared by both ends of the synchronous SRAM user port.
// Assumes qsu_defs.svh is on the include path.
`include "qsu_defs.svh"

package qsu_pkg;
  // Whole burst of data, one user cycle
  typedef logic [`QSU_MEMORY_DATA_WIDTH_PARAM*`QSU_BURST_BEATS-1:0] qsu_data_t;
  // Active-low byte-write mask, one bit per lane per beat
  typedef logic [(`QSU_MEMORY_DATA_WIDTH_PARAM/`QSU_LANE_BITS)*`QSU_BURST_BEATS-1:0] qsu_mask_t;
  // User address
  typedef logic [`QSU_ADDR_W-1:0] qsu_addr_t;
  // Debug bus
  typedef logic [7:0] qsu_dbg_t;
  // Calibration states
  typedef enum logic [1:0] {
    QSU_CAL_HOLD,
    QSU_CAL_RUN,
    QSU_CAL_DONE
  } qsu_cal_e;
endpackage

// ===== core/qsu_user.sv
// User-logic end: queues requests and drives the strobes of each port.
// Assumes the same core clock as the controller; one FIFO per port.
`timescale 1ns/1ps
`include "qsu_defs.svh"

module qsu_user (
  input wire logic i_core_clk,                            // Core clock
  input wire logic i_reset,                               // Async reset, active high
  qsu_if.user bus,                                        // Controller side
  input wire logic [`QSU_PORTS-1:0] i_req_valid,          // Request offered
  output logic [`QSU_PORTS-1:0] o_req_ready,              // Queue has room
  input wire logic [`QSU_PORTS-1:0] i_req_write,          // 1 write, 0 read
  input wire qsu_pkg::qsu_addr_t [`QSU_PORTS-1:0] i_req_loc, // Address
  input wire qsu_pkg::qsu_data_t [`QSU_PORTS-1:0] i_req_data, // Write burst
  input wire qsu_pkg::qsu_mask_t [`QSU_PORTS-1:0] i_req_mask, // Active-low mask
  output logic [`QSU_PORTS-1:0] o_ret_valid,              // Read data pulse
  output qsu_pkg::qsu_data_t [`QSU_PORTS-1:0] o_ret_data, // Read data
  output logic o_calib_done                               // Controller ready
);
  import qsu_pkg::*;

  localparam int NP = `QSU_PORTS;
  localparam int AW = $bits(qsu_addr_t);
  localparam int DW = $bits(qsu_data_t);
  localparam int MW = $bits(qsu_mask_t);
  localparam int EW = 1 + AW + DW + MW;

  logic [NP-1:0] rd_q;                  // Read strobes
  logic [NP-1:0] wr_q;                  // Write strobes
  qsu_addr_t loc_q [NP];                // Addresses
  qsu_data_t data_q [NP];               // Write bursts
  qsu_mask_t mask_q [NP];               // Masks
  logic [NP-1:0] ret_strobe;            // Returned strobes
  qsu_data_t ret_bus [NP];              // Returned bursts
  logic issue_ok;                       // Draining allowed

  // Drain only once calibration is done and reset has left
  assign issue_ok = bus.calib_done & ~bus.user_rst;

  generate
    for (genvar p = 0; p < NP; p++) begin : g_port
      logic out_valid;                  // FIFO holds a request
      logic [EW-1:0] out_word;          // Oldest request

      // Request queue; stalls while calibration runs
      qsu_fifo #(
        .WIDTH(EW),
        .DEPTH(`QSU_FIFO_DEPTH)
      ) u_fifo (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_in_valid(i_req_valid[p]),
        .o_in_ready(o_req_ready[p]),
        .i_in_data({i_req_write[p], i_req_loc[p], i_req_data[p], i_req_mask[p]}),
        .o_out_valid(out_valid),
        .i_out_ready(issue_ok),
        .o_out_data(out_word)
      );

      // One request per cycle as a single-cycle strobe
      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          rd_q[p] <= 1'b0;
          wr_q[p] <= 1'b0;
          loc_q[p] <= '0;
          data_q[p] <= '0;
          mask_q[p] <= '1;
        end else begin
          rd_q[p] <= out_valid & issue_ok & ~out_word[EW-1];
          wr_q[p] <= out_valid & issue_ok & out_word[EW-1];
          if (out_valid && issue_ok) begin
            loc_q[p] <= out_word[EW-2 -: AW];
            data_q[p] <= out_word[DW+MW-1 -: DW];
            mask_q[p] <= out_word[MW-1:0];
          end
        end
      end

      // Capture returned data in the cycle it is valid
      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          o_ret_valid[p] <= 1'b0;
          o_ret_data[p] <= '0;
        end else begin
          o_ret_valid[p] <= ret_strobe[p];
          if (ret_strobe[p]) begin
            o_ret_data[p] <= ret_bus[p];
          end
        end
      end
    end
  endgenerate

  // Port A wiring
  assign bus.port_a_read_request = rd_q[0];
  assign bus.port_a_read_location = loc_q[0];
  assign bus.port_a_write_request = wr_q[0];
  assign bus.port_a_write_location = loc_q[0];
  assign bus.port_a_write_burst_bus = data_q[0];
  assign bus.port_a_byte_write_mask_low = mask_q[0];
  assign ret_strobe[0] = bus.port_a_read_return_strobe;
  assign ret_bus[0] = bus.port_a_read_burst_bus;

  // Port B wiring, held idle in the four-word burst setup
  generate
    if (NP == 2) begin : g_b
      assign bus.port_b_read_request = rd_q[NP-1];
      assign bus.port_b_read_location = loc_q[NP-1];
      assign bus.port_b_write_request = wr_q[NP-1];
      assign bus.port_b_write_location = loc_q[NP-1];
      assign bus.port_b_write_burst_bus = data_q[NP-1];
      assign bus.port_b_byte_write_mask_low = mask_q[NP-1];
      assign ret_strobe[NP-1] = bus.port_b_read_return_strobe;
      assign ret_bus[NP-1] = bus.port_b_read_burst_bus;
    end else begin : g_nb
      assign bus.port_b_read_request = 1'b0;
      assign bus.port_b_read_location = '0;
      assign bus.port_b_write_request = 1'b0;
      assign bus.port_b_write_location = '0;
      assign bus.port_b_write_burst_bus = '0;
      assign bus.port_b_byte_write_mask_low = '1;
    end
  endgenerate

  // Calibration status mirrored to the user side
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_calib_done <= 1'b0;
    end else begin
      o_calib_done <= bus.calib_done;
    end
  end
endmodule

// ===== verification/qsu_link_assertions.sv
// Checker for the link between the controller end and the user-logic end.
// Assumes it watches the carrier's signals directly; the testbench instantiates it.
`timescale 1ns/1ps

module qsu_link_checker (
  input wire logic user_clk,                  // User clock
  input wire logic user_rst,                  // Synchronised user reset
  input wire logic calib_done,                // Calibration finished
  input wire logic port_a_read_request,       // Port A read strobe
  input wire logic port_a_read_return_strobe, // Port A read data valid
  input wire logic port_a_write_request,      // Port A write strobe
  input wire logic port_b_read_request,       // Port B read strobe
  input wire logic port_b_read_return_strobe, // Port B read data valid
  input wire logic port_b_write_request       // Port B write strobe
);
  // Read taken by the controller on each port
  sequence s_read_a;
    port_a_read_request && calib_done;
  endsequence
  sequence s_read_b;
    port_b_read_request && calib_done;
  endsequence
  // Calibration runs a fixed time after the user reset leaves, then finishes
  sequence s_cal_wait;
    !calib_done [*8] ##43 !calib_done ##1 calib_done;
  endsequence

  // Every taken read is answered three cycles later
  a_ret_follow_a: assert property (@(posedge user_clk) disable iff (user_rst)
    s_read_a |-> ##3 port_a_read_return_strobe) else $error("Port A read unanswered");
  a_ret_follow_b: assert property (@(posedge user_clk) disable iff (user_rst)
    s_read_b |-> ##3 port_b_read_return_strobe) else $error("Port B read unanswered");
  // No return without a taken read of the same port
  a_ret_cause_a: assert property (@(posedge user_clk) disable iff (user_rst)
    port_a_read_return_strobe |-> $past(port_a_read_request, 3) && $past(calib_done, 3))
    else $error("Port A return without read");
  a_ret_cause_b: assert property (@(posedge user_clk) disable iff (user_rst)
    port_b_read_return_strobe |-> $past(port_b_read_request, 3) && $past(calib_done, 3))
    else $error("Port B return without read");
  // Calibration done stays up and arrives in bounded time
  a_cal_hold: assert property (@(posedge user_clk) disable iff (user_rst)
    calib_done |=> calib_done) else $error("Calibration done dropped");
  a_cal_timing: assert property (@(posedge user_clk) disable iff (user_rst)
    $fell(user_rst) |-> s_cal_wait) else $error("Calibration time wrong");
  // Quiet outputs while in reset and before calibration
  a_reset_quiet: assert property (@(posedge user_clk)
    user_rst |-> !calib_done && !port_a_read_return_strobe && !port_b_read_return_strobe)
    else $error("Outputs active in reset");
  a_precal_quiet: assert property (@(posedge user_clk) disable iff (user_rst)
    !calib_done |-> !port_a_read_return_strobe && !port_b_read_return_strobe)
    else $error("Return before calibration");
  // The user end issues nothing before calibration
  a_user_waits: assert property (@(posedge user_clk) disable iff (user_rst)
    (port_a_read_request || port_a_write_request || port_b_read_request
    || port_b_write_request) |-> calib_done) else $error("Request before calibration");
endmodule

// ===== verification/sync_sram_user_port_tb.sv
// Testbench: both ends joined, random traffic compared with a queue model.
// Assumes the design files and qsu_defs.svh are compiled first.
`timescale 1ns/1ps
`include "qsu_defs.svh"
`define CHK(g, e) chk_val((g), (e))

module sync_sram_user_port_tb;
  import qsu_pkg::*;
  localparam int NP = `QSU_PORTS;     // User ports
  localparam int LN = $bits(qsu_mask_t); // Byte lanes per burst
  localparam int LB = `QSU_LANE_BITS; // Bits per lane
  logic clk = 1'b0; // Core clock
  logic rst = 1'b1; // Reset, active high
  logic [NP-1:0] req_valid = '0, req_write = '0, rdy, ret_valid; // Request handshake
  qsu_addr_t [NP-1:0] req_loc = '0; // Request address
  qsu_data_t [NP-1:0] req_data = '0, ret_data; // Burst data
  qsu_mask_t [NP-1:0] req_mask = '0; // Active-low lane mask
  logic calib; // Calibration done seen by the user end
  qsu_data_t mem_m [2**`QSU_ADDR_W]; // Model memory
  qsu_data_t exp_q [NP][$]; // Expected returns per port
  int acc_cnt [NP] = '{default: 0}; // Accepted pushes per port
  int error_cnt = 0;
  int checks = 0;

  // Clock generator
  initial forever #20 clk = ~clk;

  qsu_if qsu_if_inst ();
  qsu_ctrl qsu_ctrl_inst (.i_core_clk(clk), .i_sys_clk_n(~clk), .i_reset(rst),
    .bus(qsu_if_inst), .o_debug_bus());
  qsu_user qsu_user_inst (.i_core_clk(clk), .i_reset(rst), .bus(qsu_if_inst),
    .i_req_valid(req_valid), .o_req_ready(rdy), .i_req_write(req_write), .i_req_loc(req_loc),
    .i_req_data(req_data), .i_req_mask(req_mask), .o_ret_valid(ret_valid),
    .o_ret_data(ret_data), .o_calib_done(calib));
  qsu_link_checker qsu_link_checker_inst (.user_clk(qsu_if_inst.user_clk),
    .user_rst(qsu_if_inst.user_rst), .calib_done(qsu_if_inst.calib_done),
    .port_a_read_request(qsu_if_inst.port_a_read_request),
    .port_a_read_return_strobe(qsu_if_inst.port_a_read_return_strobe),
    .port_a_write_request(qsu_if_inst.port_a_write_request),
    .port_b_read_request(qsu_if_inst.port_b_read_request),
    .port_b_read_return_strobe(qsu_if_inst.port_b_read_return_strobe),
    .port_b_write_request(qsu_if_inst.port_b_write_request));

  // Compare and count
  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Present one request on a port with fresh random data
  task automatic drive(input int p, input logic v, input logic w, input qsu_addr_t a,
                       input qsu_mask_t m);
    req_valid[p] <= v;
    req_write[p] <= w;
    req_loc[p] <= a;
    req_data[p] <= qsu_data_t'({$urandom(), $urandom()});
    req_mask[p] <= m;
  endtask

  // Model: check returns, then take reads before writes of the same edge
  always @(posedge clk) begin
    if (!rst) begin
      for (int p = 0; p < NP; p++) begin
        if (ret_valid[p] === 1'b1) begin
          if (exp_q[p].size() == 0) `CHK(1'b1, 1'b0);
          else `CHK(ret_data[p], exp_q[p].pop_front());
        end
        if (req_valid[p] && rdy[p]) acc_cnt[p]++;
        if (req_valid[p] && rdy[p] && !req_write[p]) exp_q[p].push_back(mem_m[req_loc[p]]);
      end
      for (int p = 0; p < NP; p++) begin
        for (int l = 0; l < LN; l++) begin
          // Low mask bit writes that lane
          if (req_valid[p] && rdy[p] && req_write[p] && !req_mask[p][l]) begin
            mem_m[req_loc[p]][LB*l +: LB] = req_data[p][LB*l +: LB];
          end
        end
      end
    end else begin
      // Reset drops every read still queued or in flight
      for (int p = 0; p < NP; p++) exp_q[p].delete();
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'hFA2399A6));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    // Fill both queues with full writes while calibration stalls the far side
    for (int i = 0; i < 36; i++) begin
      for (int p = 0; p < NP; p++) drive(p, 1'b1, 1'b1, qsu_addr_t'(p*16+i%16), '0);
      @(posedge clk);
    end
    for (int p = 0; p < NP; p++) drive(p, 1'b0, 1'b0, '0, '1);
    @(negedge clk);
    `CHK(rdy, '0);
    `CHK(acc_cnt[0], 32);
    `CHK(calib, 1'b0);
    for (int i = 0; i < 200 && calib !== 1'b1; i++) @(posedge clk);
    `CHK(calib, 1'b1);
    repeat (40) @(posedge clk);
    // Random mixed traffic, back to back and with gaps, on both ports
    repeat (400) begin
      for (int p = 0; p < NP; p++) begin
        drive(p, $urandom % 4 != 0, 1'($urandom), qsu_addr_t'(p*16+$urandom%16),
              qsu_mask_t'($urandom));
      end
      @(posedge clk);
    end
    for (int p = 0; p < NP; p++) drive(p, 1'b0, 1'b0, '0, '1);
    repeat (40) @(posedge clk);
    // Reset in mid-run with a read in flight on each port: nothing returns
    for (int p = 0; p < NP; p++) drive(p, 1'b1, 1'b0, qsu_addr_t'(p*16), '1);
    @(posedge clk);
    for (int p = 0; p < NP; p++) drive(p, 1'b0, 1'b0, '0, '1);
    repeat (2) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK({qsu_if_inst.calib_done, qsu_if_inst.port_a_read_return_strobe}, '0);
    @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 200 && calib !== 1'b1; i++) @(posedge clk);
    `CHK(calib, 1'b1);
    repeat (4) @(posedge clk);
    // Read and write of one address in the same cycle: the read sees old data
    drive(0, 1'b1, 1'b0, 8'h03, '1);
    drive(1, 1'b1, 1'b1, 8'h03, '0);
    @(posedge clk);
    drive(1, 1'b0, 1'b0, '0, '1);
    @(posedge clk);
    drive(0, 1'b0, 1'b0, '0, '1);
    repeat (3) @(posedge clk);
    drive(0, 1'b1, 1'b0, 8'h03, '1);
    @(posedge clk);
    drive(0, 1'b0, 1'b0, '0, '1);
    repeat (40) @(posedge clk);
    for (int p = 0; p < NP; p++) `CHK(exp_q[p].size(), 0);
    end_of_test();
  end

  // Watchdog
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
endmodule
